/* File: src/dcah_defines.svh */
// constants for the shared-bus transfer hazard model
// assumes a 20-bit system address space and 16-bit processor data
`ifndef DCAH_DEFINES_SVH
`define DCAH_DEFINES_SVH

`define DCAH_SA_ADDR   20'h0_0010
`define DCAH_DA_ADDR   20'h0_0014
`define DCAH_IFG_ADDR  20'h0_0020
`define DCAH_STACK_LO  20'h0_2000
`define DCAH_STACK_HI  20'h0_3FFF
`define DCAH_ADDR_RST  20'h0_0000
`define DCAH_FLAG_RST  16'h0000
`define DCAH_HI_MSB    19
`define DCAH_HI_LSB    16

`endif

/* File: src/dcah_pkg.sv */
// types shared by the shared-bus transfer hazard model
// assumes nothing beyond a single system clock
package dcah_pkg;

  typedef logic [19:0] dcah_addr_t;
  typedef logic [15:0] dcah_word_t;

  typedef enum logic [2:0]
  {
    DCAH_CPU_SINGLE,
    DCAH_CPU_WIDE_LO,
    DCAH_CPU_WIDE_HI,
    DCAH_CPU_RMW_RD,
    DCAH_CPU_RMW_WR
  } dcah_kind_e;

  typedef struct packed {
    logic       valid;
    logic       we;
    dcah_kind_e kind;
    dcah_addr_t addr;
    dcah_word_t wdata;
  } dcah_cpu_s;

  typedef struct packed {
    logic       we;
    dcah_addr_t addr;
    dcah_addr_t wdata;
  } dcah_dma_s;

  typedef struct packed {
    logic       valid;
    logic       we;
    dcah_addr_t addr;
    dcah_addr_t wdata;
  } dcah_mem_s;

endpackage

/* File: src/dcah_top.sv */
// shared system bus between processor and transfer controller, with hazards
// assumes processor holds its access while cpu_wait_o is high
`timescale 1ns/100ps
`default_nettype none
`include "dcah_defines.svh"

// Behaviour
// - wide address write split by a transfer leaves a mixed, unreliable value
// - transfer inside flag read-modify-write drops newly arriving events
// - flags set before the transfer stay set through the overlap
// - transfer write to stack during wide stack instruction corrupts data
module dcah_top
(
  input  wire logic                sys_clk_i,              // system clock
  input  wire logic                resetn_i,               // sync reset, low
  input  wire dcah_pkg::dcah_cpu_s cpu_i,                  // processor access
  input  wire logic                cpu_stack_i,            // wide stack instr
  input  wire logic                dma_req_i,              // transfer request
  input  wire dcah_pkg::dcah_dma_s dma_i,                  // transfer access
  input  wire logic                channel_active_i,       // channel enable
  input  wire logic                rmw_transfer_inhibit_i, // hold off in rmw or wide write
  input  wire dcah_pkg::dcah_word_t irq_set_i,             // flag set pulses
  output logic                     cpu_wait_o,             // processor stall
  output logic                     dma_gnt_o,              // bus to controller
  output dcah_pkg::dcah_mem_s      mem_o,                  // bus to memory
  output dcah_pkg::dcah_word_t     cpu_rdata_o,            // flag read data
  output dcah_pkg::dcah_addr_t     channel_source_address_o,      // source
  output dcah_pkg::dcah_addr_t     channel_destination_address_o, // dest
  output dcah_pkg::dcah_word_t     irq_flags_o,            // peripheral flags
  output logic                     split_evt_o,            // wide write split
  output logic                     lost_evt_o,             // events dropped
  output logic                     stack_hz_o              // stack corrupted
);
  import dcah_pkg::*;

  function automatic logic addr_hit(input dcah_addr_t a, input dcah_addr_t r);
    addr_hit = (a == r);
  endfunction

  function automatic logic in_stack(input dcah_addr_t a);
    in_stack = (a >= `DCAH_STACK_LO) && (a <= `DCAH_STACK_HI);
  endfunction

  logic       gnt_q,    gnt_d;
  dcah_mem_s  mem_q,    mem_d;
  dcah_word_t rdata_q,  rdata_d;
  dcah_addr_t sa_q,     sa_d;
  dcah_addr_t da_q,     da_d;
  dcah_word_t flags_q,  flags_d;
  dcah_word_t pend_q,   pend_d;
  dcah_word_t lo_q,     lo_d;
  logic       tgt_da_q, tgt_da_d;
  logic       wopen_q,  wopen_d;
  logic       split_q,  split_d;
  logic       ropen_q,  ropen_d;
  logic       lost_q,   lost_d;
  logic       sev_q,    sev_d;
  logic       lev_q,    lev_d;
  logic       shz_q,    shz_d;
  dcah_addr_t wide_val;

  always_comb
  begin
    gnt_d    = 1'b0;
    mem_d    = '0;
    rdata_d  = rdata_q;
    sa_d     = sa_q;
    da_d     = da_q;
    flags_d  = flags_q | irq_set_i;
    pend_d   = ropen_q ? (pend_q | irq_set_i) : '0;
    lo_d     = lo_q;
    tgt_da_d = tgt_da_q;
    wopen_d  = wopen_q;
    split_d  = split_q;
    ropen_d  = ropen_q;
    lost_d   = lost_q;
    sev_d    = 1'b0;
    lev_d    = 1'b0;
    shz_d    = 1'b0;
    wide_val = split_q ? {cpu_i.wdata[3:0], (tgt_da_q ? da_q[15:0] : sa_q[15:0])}
                       : {cpu_i.wdata[3:0], lo_q};
    if (gnt_q)
    begin
      // stolen cycle; processor access waits
      mem_d = '{valid: 1'b1, we: dma_i.we, addr: dma_i.addr, wdata: dma_i.wdata};
      if (dma_i.we && cpu_stack_i && in_stack(dma_i.addr))
      begin
        mem_d.wdata[`DCAH_HI_MSB:`DCAH_HI_LSB] = ~dma_i.wdata[`DCAH_HI_MSB:`DCAH_HI_LSB];
        shz_d = 1'b1;
      end
      if (wopen_q)
        split_d = 1'b1;
      if (ropen_q)
        lost_d = 1'b1;
    end
    else if (cpu_i.valid)
    begin
      if (addr_hit(cpu_i.addr, `DCAH_IFG_ADDR))
      begin
        unique case (cpu_i.kind)
          DCAH_CPU_RMW_RD:
          begin
            rdata_d = flags_q;
            ropen_d = 1'b1;
            lost_d  = 1'b0;
            pend_d  = irq_set_i; // event missing from the snapshot
          end
          DCAH_CPU_RMW_WR:
          begin
            // write-back keeps snapshot bits; window events only if no steal
            flags_d = cpu_i.wdata | irq_set_i | (lost_q ? '0 : pend_q);
            ropen_d = 1'b0;
            lost_d  = 1'b0;
            lev_d   = lost_q && (pend_q != '0);
          end
          default:
          begin
            if (cpu_i.we)
              flags_d = cpu_i.wdata | irq_set_i;
            else
              rdata_d = flags_q;
          end
        endcase
      end
      else if (addr_hit(cpu_i.addr, `DCAH_SA_ADDR) || addr_hit(cpu_i.addr, `DCAH_DA_ADDR))
      begin
        if (cpu_i.we && cpu_i.kind == DCAH_CPU_WIDE_LO)
        begin
          lo_d     = cpu_i.wdata;
          tgt_da_d = addr_hit(cpu_i.addr, `DCAH_DA_ADDR);
          wopen_d  = 1'b1;
          split_d  = 1'b0;
        end
        else if (cpu_i.we && cpu_i.kind == DCAH_CPU_WIDE_HI && wopen_q)
        begin
          if (tgt_da_q)
            da_d = wide_val;
          else
            sa_d = wide_val;
          wopen_d = 1'b0;
          split_d = 1'b0;
          sev_d   = split_q;
        end
        else if (cpu_i.we && cpu_i.kind == DCAH_CPU_SINGLE)
        begin
          if (addr_hit(cpu_i.addr, `DCAH_DA_ADDR))
            da_d = {4'h0, cpu_i.wdata};
          else
            sa_d = {4'h0, cpu_i.wdata};
        end
      end
      else
      begin
        mem_d = '{valid: 1'b1, we: cpu_i.we, addr: cpu_i.addr, wdata: {4'h0, cpu_i.wdata}};
      end
    end
    // steal next cycle if channel active, unless held off inside an open sequence
    gnt_d = dma_req_i && channel_active_i
            && !(rmw_transfer_inhibit_i && (wopen_d || ropen_d));
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      gnt_q    <= 1'b0;
      mem_q    <= '0;
      rdata_q  <= '0;
      sa_q     <= `DCAH_ADDR_RST;
      da_q     <= `DCAH_ADDR_RST;
      flags_q  <= `DCAH_FLAG_RST;
      pend_q   <= '0;
      lo_q     <= '0;
      tgt_da_q <= 1'b0;
      wopen_q  <= 1'b0;
      split_q  <= 1'b0;
      ropen_q  <= 1'b0;
      lost_q   <= 1'b0;
      sev_q    <= 1'b0;
      lev_q    <= 1'b0;
      shz_q    <= 1'b0;
    end
    else
    begin
      gnt_q    <= gnt_d;
      mem_q    <= mem_d;
      rdata_q  <= rdata_d;
      sa_q     <= sa_d;
      da_q     <= da_d;
      flags_q  <= flags_d;
      pend_q   <= pend_d;
      lo_q     <= lo_d;
      tgt_da_q <= tgt_da_d;
      wopen_q  <= wopen_d;
      split_q  <= split_d;
      ropen_q  <= ropen_d;
      lost_q   <= lost_d;
      sev_q    <= sev_d;
      lev_q    <= lev_d;
      shz_q    <= shz_d;
    end
  end

  assign cpu_wait_o                    = gnt_q;
  assign dma_gnt_o                     = gnt_q;
  assign mem_o                         = mem_q;
  assign cpu_rdata_o                   = rdata_q;
  assign channel_source_address_o      = sa_q;
  assign channel_destination_address_o = da_q;
  assign irq_flags_o                   = flags_q;
  assign split_evt_o                   = sev_q;
  assign lost_evt_o                    = lev_q;
  assign stack_hz_o                    = shz_q;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  logic cpu_hi_w;
  assign cpu_hi_w = !gnt_q && cpu_i.valid && cpu_i.we && cpu_i.kind == DCAH_CPU_WIDE_HI
                    && wopen_q && !tgt_da_q && addr_hit(cpu_i.addr, `DCAH_SA_ADDR);

  a_split_mixes: assert property (cpu_hi_w && split_q |=>
    sa_q == {$past(cpu_i.wdata[3:0]), $past(sa_q[15:0])} && split_evt_o)
    else $error("split wide write did not keep stale low half");
  a_clean_wide: assert property (cpu_hi_w && !split_q |=>
    sa_q == {$past(cpu_i.wdata[3:0]), $past(lo_q)} && !split_evt_o)
    else $error("unsplit wide write value wrong");
  a_inhibit_holds: assert property (rmw_transfer_inhibit_i && !gnt_q && cpu_i.valid
    && ((cpu_i.kind == DCAH_CPU_RMW_RD && addr_hit(cpu_i.addr, `DCAH_IFG_ADDR))
    || (cpu_i.we && cpu_i.kind == DCAH_CPU_WIDE_LO && addr_hit(cpu_i.addr, `DCAH_SA_ADDR)))
    |=> !dma_gnt_o)
    else $error("transfer granted inside inhibited sequence");
  a_word_upper: assert property (!gnt_q && cpu_i.valid && cpu_i.we
    && cpu_i.kind == DCAH_CPU_SINGLE && addr_hit(cpu_i.addr, `DCAH_DA_ADDR)
    |=> channel_destination_address_o == {4'h0, $past(cpu_i.wdata)})
    else $error("word write did not clear upper address bits");
  a_rmw_drop: assert property (!gnt_q && cpu_i.valid && cpu_i.kind == DCAH_CPU_RMW_WR
    && addr_hit(cpu_i.addr, `DCAH_IFG_ADDR) && lost_q
    |=> irq_flags_o == ($past(cpu_i.wdata) | $past(irq_set_i)))
    else $error("stolen rmw kept window events");
  a_flag_keep: assert property (irq_flags_o != '0 && !(cpu_i.valid && !gnt_q
    && addr_hit(cpu_i.addr, `DCAH_IFG_ADDR)) |=> (irq_flags_o & $past(irq_flags_o))
    == $past(irq_flags_o))
    else $error("set flag cleared without processor write");
  a_stack_corrupt: assert property (gnt_q && dma_i.we && cpu_stack_i && in_stack(dma_i.addr)
    |=> stack_hz_o && mem_o.wdata[19:16] == ~$past(dma_i.wdata[19:16]))
    else $error("stack hazard not applied");
  a_gnt_cause: assert property (dma_gnt_o |-> $past(dma_req_i) && $past(channel_active_i)
    ##1 mem_o.valid && mem_o.addr == $past(dma_i.addr))
    else $error("grant without request or stolen cycle not on bus");

  c_split:  cover property (cpu_hi_w && split_q);
  c_lost:   cover property (lost_evt_o);
  c_stack:  cover property (stack_hz_o);
  c_steal2: cover property (dma_gnt_o [*2] ##1 !dma_gnt_o);

endmodule

`default_nettype wire

/* File: verif/dcah_cpu_model.sv */
// processor model: queued accesses on the shared bus
// assumes the bench calls issue() off the clock edge
`timescale 1ns/100ps
`default_nettype none
module dcah_cpu_model
(
  input  wire logic              sys_clk_i,  // system clock
  input  wire logic              cpu_wait_i, // cycle stolen
  output var dcah_pkg::dcah_cpu_s cpu_o      // processor access
);
  import dcah_pkg::*;
  dcah_cpu_s q[$];
  initial cpu_o = '0;
  task automatic issue(input dcah_cpu_s acc);
    q.push_back(acc);
  endtask
  function automatic bit pending();
    return (q.size() != 0) || (cpu_o.valid === 1'b1);
  endfunction
  // access held until an edge with no stolen cycle
  always @(posedge sys_clk_i)
  begin
    if (!cpu_o.valid || !cpu_wait_i)
    begin
      if (q.size() != 0)
        cpu_o <= q.pop_front();
      else
        cpu_o <= dcah_cpu_s'({1'b0, ~cpu_o[$bits(dcah_cpu_s)-2:0]});
    end
  end
endmodule
`default_nettype wire

/* File: verif/dcah_top_tb_top.sv */
// self-checking bench for the shared-bus hazard model
// assumes the processor model in dcah_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none
`include "dcah_defines.svh"
module dcah_top_tb_top;
  import dcah_pkg::*;
  logic       sys_clk_i = 1'b0;
  logic       resetn_i = 1'b0;
  dcah_cpu_s  cpu_i;
  logic       cpu_stack_i = 1'b0;
  logic       dma_req_i = 1'b0;
  dcah_dma_s  dma_i = '0;
  logic       chan_on = 1'b1;
  logic       inhibit = 1'b0;
  dcah_word_t irq_set_i = '0;
  logic       cpu_wait_o, dma_gnt_o, split_evt_o, lost_evt_o, stack_hz_o;
  dcah_mem_s  mem_o;
  dcah_word_t cpu_rdata_o, irq_flags_o;
  dcah_addr_t src_addr, dst_addr, a, d;
  dcah_word_t w1, w2;
  int         err_total = 0, compares = 0, m_sa = 0, m_fl = 0;
  int         n_split = 0, n_lost = 0, n_hz = 0, n_gnt = 0;
  int         e_split = 0, e_lost = 0, e_hz = 0, e_gnt = 0;
  integer     seed = 32'hfd1ec9a4;
  dcah_addr_t mq[$], eq[$];
  always #5 sys_clk_i = ~sys_clk_i;
  dcah_cpu_model dcah_cpu_model_i (.sys_clk_i(sys_clk_i), .cpu_wait_i(cpu_wait_o), .cpu_o(cpu_i));
  dcah_top dcah_top_i (.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .cpu_i(cpu_i),
    .cpu_stack_i(cpu_stack_i), .dma_req_i(dma_req_i), .dma_i(dma_i),
    .channel_active_i(chan_on), .rmw_transfer_inhibit_i(inhibit), .irq_set_i(irq_set_i),
    .cpu_wait_o(cpu_wait_o), .dma_gnt_o(dma_gnt_o), .mem_o(mem_o), .cpu_rdata_o(cpu_rdata_o),
    .channel_source_address_o(src_addr), .channel_destination_address_o(dst_addr),
    .irq_flags_o(irq_flags_o), .split_evt_o(split_evt_o), .lost_evt_o(lost_evt_o),
    .stack_hz_o(stack_hz_o));
  always @(posedge sys_clk_i)
  begin
    n_split <= n_split + int'(split_evt_o === 1'b1);
    n_lost  <= n_lost + int'(lost_evt_o === 1'b1);
    n_hz    <= n_hz + int'(stack_hz_o === 1'b1);
    n_gnt   <= n_gnt + int'(dma_gnt_o === 1'b1 && cpu_wait_o === 1'b1);
    if (mem_o.valid === 1'b1)
    begin
      mq.push_back(mem_o.addr);
      mq.push_back(mem_o.wdata);
    end
  end
  task automatic give_verdict();
    if (err_total == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic [15:0] got, input logic [15:0] exp);
    chk({4'h0, got}, {4'h0, exp});
  endtask
  task automatic chk_cnt(input int got, input int exp);
    chk(20'(got), 20'(exp));
  endtask
  function automatic dcah_cpu_s acc(dcah_kind_e k, dcah_addr_t ad, dcah_word_t w);
    return '{1'b1, 1'b1, k, ad, w};
  endfunction
  task automatic settle();
    int n;
    n = 0;
    while (dcah_cpu_model_i.pending() && n < 50)
    begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    if (n == 50)
      chk(20'h0_0001, 20'h0_0000);
    repeat (4) @(posedge sys_clk_i);
  endtask
  initial
  begin
    #100000;
    err_total++;
    give_verdict();
  end
  initial
  begin
    repeat (5) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    for (int k = 0; k < 2; k++)
    begin
      #1;
      w1 = 16'($random(seed));
      dcah_cpu_model_i.issue(acc(DCAH_CPU_SINGLE, k ? `DCAH_DA_ADDR : `DCAH_SA_ADDR, w1));
      settle();
      chk(k ? dst_addr : src_addr, {4'h0, w1});
    end
    for (int md = 0; md < 3; md++)
    begin
      m_sa = src_addr;
      inhibit <= (md == 1);
      chan_on <= (md != 2);
      #1;
      w1 = 16'($random(seed));
      w2 = 16'($random(seed));
      dcah_cpu_model_i.issue(acc(DCAH_CPU_WIDE_LO, `DCAH_SA_ADDR, w1));
      dcah_cpu_model_i.issue(acc(DCAH_CPU_WIDE_HI, `DCAH_SA_ADDR, w2));
      @(posedge sys_clk_i) dma_req_i <= 1'b1;
      @(posedge sys_clk_i) dma_req_i <= 1'b0;
      settle();
      m_sa = (md == 0) ? {w2[3:0], m_sa[15:0]} : {w2[3:0], w1};
      e_split += int'(md == 0);
      chk(src_addr, 20'(m_sa));
      chk_cnt(n_split, e_split);
      #1;
      dcah_cpu_model_i.issue(acc(DCAH_CPU_SINGLE, `DCAH_IFG_ADDR, 16'h0000));
      settle();
      irq_set_i <= 16'h0001;
      @(posedge sys_clk_i) irq_set_i <= 16'h0000;
      #1;
      dcah_cpu_model_i.issue(acc(DCAH_CPU_RMW_RD, `DCAH_IFG_ADDR, 16'h0000));
      dcah_cpu_model_i.issue(acc(DCAH_CPU_RMW_WR, `DCAH_IFG_ADDR, 16'h0001));
      @(posedge sys_clk_i) dma_req_i <= 1'b1;
      @(posedge sys_clk_i)
      begin
        dma_req_i <= 1'b0;
        irq_set_i <= 16'h0010;
      end
      @(posedge sys_clk_i) irq_set_i <= 16'h0000;
      settle();
      m_fl = (md == 0) ? 1 : 17;
      e_lost += int'(md == 0);
      e_gnt += (md == 0) ? 2 : 0;
      chk_flag(cpu_rdata_o, 16'h0001);
      chk_flag(irq_flags_o, 16'(m_fl));
      chk_cnt(n_lost, e_lost);
      chk_cnt(n_gnt, e_gnt);
    end
    chan_on <= 1'b1;
    mq.delete();
    #1;
    w1 = 16'($random(seed));
    dcah_cpu_model_i.issue(acc(DCAH_CPU_SINGLE, 20'h0_9000, w1));
    settle();
    eq.push_back(20'h0_9000);
    eq.push_back({4'h0, w1});
    for (int k = 0; k < 6; k++)
    begin
      a = k[0] ? (`DCAH_STACK_LO | (20'($random(seed)) & 20'h0_1FFF)) : 20'h0_8000 + 20'(k);
      d = 20'($random(seed));
      cpu_stack_i <= k[1];
      dma_i <= '{1'b1, a, d};
      dma_req_i <= 1'b1;
      @(posedge sys_clk_i) dma_req_i <= 1'b0;
      eq.push_back(a);
      eq.push_back((k[0] & k[1]) ? d ^ 20'hF_0000 : d);
      e_hz += int'(k[0] & k[1]);
      repeat (4) @(posedge sys_clk_i);
    end
    chk_cnt(mq.size(), eq.size());
    while (eq.size() != 0)
      chk(mq.pop_front(), eq.pop_front());
    chk_cnt(n_hz, e_hz);
    give_verdict();
  end
endmodule
`default_nettype wire
